// File: acsc_pkg.sv
// package: constants and types for the codec serial control port
package acsc_pkg;
   localparam int unsigned BYTE_BITS = 8;
   localparam logic [3:0] BIT_CNT_RST = 4'h0;
   // idle levels of {phase, clock, data} pins, reset value of the synchroniser
   localparam logic [2:0] PIN_IDLE = 3'h6;
   localparam logic [3:0] BIT_CNT_LAST = 4'h7;
   localparam logic [1:0] TYPE_GENERAL = 2'h0;
   localparam logic [1:0] TYPE_STATUS = 2'h2;
   localparam int unsigned ADDR_MSB = 7;
   localparam int unsigned ADDR_LSB = 2;
   localparam logic [5:0] OWN_ADDR_DEFAULT = 6'h0a;
   localparam logic [1:0] SEL_VOLUME = 2'h0;
   localparam logic [1:0] SEL_TONE = 2'h1;
   localparam logic [1:0] SEL_MODE = 2'h2;
   localparam logic [1:0] SEL_POWER = 2'h3;
   localparam logic [5:0] VOLUME_RST = 6'h00;
   localparam logic [3:0] BASS_RST = 4'h0;
   localparam logic [1:0] TREBLE_RST = 2'h0;
   localparam logic [1:0] DEEMPH_RST = 2'h0;
   localparam logic MUTE_RST = 1'b0;
   localparam logic [1:0] FILT_MODE_RST = 2'h0;
   localparam logic [1:0] POWER_RST = 2'h0;
   localparam logic [1:0] CLK_RATIO_RST = 2'h0;
   localparam logic [2:0] IN_FMT_RST = 3'h0;
   localparam logic DC_FILT_RST = 1'b0;
   localparam logic [1:0] RATIO_512 = 2'h0;
   localparam logic [1:0] RATIO_384 = 2'h1;
   localparam logic [1:0] RATIO_256 = 2'h2;
   localparam logic [9:0] FS_MULT_512 = 10'h200;
   localparam logic [9:0] FS_MULT_384 = 10'h180;
   localparam logic [9:0] FS_MULT_256 = 10'h100;
   localparam logic [2:0] FMT_MAX_USED = 3'h4;
   // link clock minimum half period, in ns and pclk cycles (64 fs ceiling kept by the half_sel clamp in the controller)
   localparam int unsigned LINK_HALF_NS = 200;
   localparam int unsigned PCLK_NS = 50;
   localparam logic [7:0] LINK_HALF_CYC = 8'((LINK_HALF_NS + PCLK_NS - 1) / PCLK_NS);
   localparam logic [7:0] PHASE_GAP_CYC = 8'h04;
   // controller APB register offsets
   localparam logic [11:0] OFF_CMD = 12'h000;
   localparam logic [11:0] OFF_STAT = 12'h004;
   localparam logic [11:0] OFF_DIV = 12'h008;
   localparam logic [31:0] DIV_RST = 32'h0000_0004;
   typedef enum logic [1:0] {ACSC_XF_GENERAL, ACSC_XF_STATUS, ACSC_XF_NONE} acsc_xfer_t;
   typedef enum {ACSC_H_IDLE, ACSC_H_SETUP, ACSC_H_LOW, ACSC_H_HIGH, ACSC_H_GAP} acsc_hstate_t;
endpackage

// File: acsc_if.sv
// interface: three-wire control link between controller and codec
`timescale 1ns/1ps
interface acsc_if;
   logic ctrl_phase_line;
   logic ctrl_serial_clock;
   logic ctrl_serial_data;
   modport ctrl
   (
      output ctrl_phase_line,
      output ctrl_serial_clock,
      output ctrl_serial_data
   );
   modport dev
   (
      input ctrl_phase_line,
      input ctrl_serial_clock,
      input ctrl_serial_data
   );
endinterface

// File: acsc_sync.sv
// module: two-flop synchroniser for a bundle of pin inputs
`timescale 1ns/1ps
module acsc_sync
#(
   parameter int unsigned W = 3,
   parameter logic [W-1:0] RST_VAL = '0
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   logic [W-1:0] meta_ff;
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         meta_ff <= RST_VAL;
         dout <= RST_VAL;
      end
      else
      begin
         meta_ff <= din;
         dout <= meta_ff;
      end
   end
endmodule

// File: acsc_dev.sv
// module: codec end, receives address and data bytes, holds feature settings
`timescale 1ns/1ps
// Function
// - mode low, eight clocks: one address byte
// - address bits 1:0 choose transfer type
// - address bits 7:2 compared to own address
// - mismatch deselects, data ignored until readdressed
// - selection holds across data bytes
// - all transfers whole bytes, same clocking
// - store only after eighth bit
// - controller clock at most 64 fs
// - data bits 7:6 select, 5:0 value
// - general and status types reach features
// - device never drives data line
// - system supplies locked system clock
// - clock ratio 256, 384 or 512 fs
// - status byte fields; bit7 set ignored
// - general byte field decode per selector
// - ratio codes 512, 384, 256, unused
// - input format codes, 101-111 unused
module acsc_dev
#(
   parameter logic [5:0] OWN_ADDR = acsc_pkg::OWN_ADDR_DEFAULT // arbitrary value
)
(
   input wire logic pclk,
   input wire logic presetn,
   acsc_if.dev link,
   output logic [5:0] volume,
   output logic [3:0] bass_boost,
   output logic [1:0] treble,
   output logic [1:0] deemphasis,
   output logic mute,
   output logic [1:0] filter_mode,
   output logic [1:0] power_ctrl,
   output logic [1:0] clk_ratio,
   output logic [9:0] fs_multiple,
   output logic ratio_valid,
   output logic [2:0] input_format,
   output logic format_valid,
   output logic dc_filter_en,
   output logic selected,
   output logic byte_stored
);
   import acsc_pkg::*;
   logic [2:0] pins_s;
   logic phase_s, sclk_s, sdata_s;
   logic sclk_d_ff, phase_d_ff;
   logic [3:0] bit_cnt_ff;
   logic [6:0] shift_ff;
   logic sel_ff;
   acsc_xfer_t xfer_ff;
   logic rise, phase_fall, byte_done;
   logic [7:0] rx_byte;

   function automatic logic [9:0] ratio_mult(input logic [1:0] code);
      unique case (code)
         RATIO_512: ratio_mult = FS_MULT_512;
         RATIO_384: ratio_mult = FS_MULT_384;
         RATIO_256: ratio_mult = FS_MULT_256;
         default: ratio_mult = FS_MULT_512;
      endcase
   endfunction

   // completed data byte for the addressed device in the given group
   function automatic logic data_hit(input acsc_xfer_t grp);
      data_hit = byte_done && phase_s && sel_ff && (xfer_ff == grp);
   endfunction

   acsc_sync #(.W(3), .RST_VAL(PIN_IDLE)) u_sync
   (
      .pclk(pclk),
      .presetn(presetn),
      .din({link.ctrl_phase_line, link.ctrl_serial_clock, link.ctrl_serial_data}),
      .dout(pins_s)
   );
   assign {phase_s, sclk_s, sdata_s} = pins_s;
   // data is sampled at the rising serial clock edge
   assign rise = sclk_s & ~sclk_d_ff;
   assign phase_fall = phase_d_ff & ~phase_s;
   assign byte_done = rise && (bit_cnt_ff == BIT_CNT_LAST);
   assign rx_byte = {shift_ff, sdata_s};

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         // idle levels, so leaving reset shows no false edge
         sclk_d_ff <= PIN_IDLE[1];
         phase_d_ff <= PIN_IDLE[2];
      end
      else
      begin
         sclk_d_ff <= sclk_s;
         phase_d_ff <= phase_s;
      end
   end

   // bit counter and shifter, msb first
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         bit_cnt_ff <= BIT_CNT_RST;
         shift_ff <= '0;
      end
      else if (phase_fall)
      begin
         bit_cnt_ff <= BIT_CNT_RST;
      end
      else if (rise)
      begin
         shift_ff <= rx_byte[6:0];
         bit_cnt_ff <= byte_done ? BIT_CNT_RST : bit_cnt_ff + 4'h1;
      end
   end

   // address phase: selection and transfer type
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sel_ff <= 1'b0;
         xfer_ff <= ACSC_XF_NONE;
      end
      else if (byte_done && !phase_s)
      begin
         sel_ff <= (rx_byte[ADDR_MSB:ADDR_LSB] == OWN_ADDR);
         if (rx_byte[1:0] == TYPE_GENERAL)
            xfer_ff <= ACSC_XF_GENERAL;
         else if (rx_byte[1:0] == TYPE_STATUS)
            xfer_ff <= ACSC_XF_STATUS;
         else
            xfer_ff <= ACSC_XF_NONE;
      end
   end

   // general feature registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         volume <= VOLUME_RST;
         bass_boost <= BASS_RST;
         treble <= TREBLE_RST;
         deemphasis <= DEEMPH_RST;
         mute <= MUTE_RST;
         filter_mode <= FILT_MODE_RST;
         power_ctrl <= POWER_RST;
      end
      else if (data_hit(ACSC_XF_GENERAL))
      begin
         unique case (rx_byte[7:6])
            SEL_VOLUME: volume <= rx_byte[5:0];
            SEL_TONE:
            begin
               bass_boost <= rx_byte[5:2];
               treble <= rx_byte[1:0];
            end
            SEL_MODE:
            begin
               deemphasis <= rx_byte[4:3];
               mute <= rx_byte[2];
               filter_mode <= rx_byte[1:0];
            end
            SEL_POWER: power_ctrl <= rx_byte[1:0];
         endcase
      end
   end

   // status registers; bit 7 set is ignored
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         clk_ratio <= CLK_RATIO_RST;
         fs_multiple <= FS_MULT_512;
         ratio_valid <= 1'b1;
         input_format <= IN_FMT_RST;
         format_valid <= 1'b1;
         dc_filter_en <= DC_FILT_RST;
      end
      else if (data_hit(ACSC_XF_STATUS) && !rx_byte[7])
      begin
         clk_ratio <= rx_byte[5:4];
         fs_multiple <= ratio_mult(rx_byte[5:4]);
         ratio_valid <= (rx_byte[5:4] != 2'h3);
         input_format <= rx_byte[3:1];
         format_valid <= (rx_byte[3:1] <= FMT_MAX_USED);
         dc_filter_en <= rx_byte[0];
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         selected <= 1'b0;
         byte_stored <= 1'b0;
      end
      else
      begin
         selected <= sel_ff;
         byte_stored <= data_hit(ACSC_XF_GENERAL)
            || (data_hit(ACSC_XF_STATUS) && !rx_byte[7]);
      end
   end
   // receive only: nothing here drives the data line
endmodule

// File: acsc_ctrl.sv
// module: controller end, APB slave that shifts address and data bytes out
`timescale 1ns/1ps
module acsc_ctrl
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   acsc_if.ctrl link
);
   import acsc_pkg::*;
   acsc_hstate_t st_ff;
   logic [7:0] sh_ff;
   logic [3:0] cnt_ff;
   logic [7:0] tmr_ff;
   logic [7:0] half_ff;
   logic addr_ph_ff;
   logic busy;
   logic wr_cmd, acc;
   logic [7:0] half_sel;

   assign busy = (st_ff != ACSC_H_IDLE);
   assign acc = psel && penable;
   assign wr_cmd = acc && pwrite && (paddr == OFF_CMD) && !busy;
   assign half_sel = (half_ff < LINK_HALF_CYC) ? LINK_HALF_CYC : half_ff;

   // apb slave: single-cycle access phase
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
         half_ff <= DIV_RST[7:0];
      end
      else
      begin
         pready <= psel && !penable;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
         if (psel && !penable)
         begin
            if (paddr != OFF_CMD && paddr != OFF_STAT && paddr != OFF_DIV)
               pslverr <= 1'b1;
            else if (pwrite && paddr == OFF_CMD && busy)
               pslverr <= 1'b1;
            else if (!pwrite && paddr == OFF_STAT)
               prdata <= {31'h0000_0000, busy};
            else if (!pwrite && paddr == OFF_DIV)
               prdata <= {24'h00_0000, half_ff};
         end
         if (acc && pwrite && paddr == OFF_DIV)
            half_ff <= pwdata[7:0];
      end
   end

   // shift engine: cmd bit 8 = address phase, bits 7:0 byte
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         st_ff <= ACSC_H_IDLE;
         sh_ff <= 8'h00;
         cnt_ff <= BIT_CNT_RST;
         tmr_ff <= 8'h00;
         addr_ph_ff <= 1'b0;
         link.ctrl_phase_line <= 1'b1;
         link.ctrl_serial_clock <= 1'b1;
         link.ctrl_serial_data <= 1'b0;
      end
      else
      begin
         unique case (st_ff)
            ACSC_H_IDLE:
               if (wr_cmd)
               begin
                  sh_ff <= pwdata[7:0];
                  addr_ph_ff <= pwdata[8];
                  link.ctrl_phase_line <= ~pwdata[8];
                  cnt_ff <= BIT_CNT_RST;
                  tmr_ff <= PHASE_GAP_CYC;
                  st_ff <= ACSC_H_SETUP;
               end
            ACSC_H_SETUP:
               if (tmr_ff <= 8'h01)
               begin
                  link.ctrl_serial_clock <= 1'b0;
                  link.ctrl_serial_data <= sh_ff[7];
                  tmr_ff <= half_sel;
                  st_ff <= ACSC_H_LOW;
               end
               else
                  tmr_ff <= tmr_ff - 8'h01;
            ACSC_H_LOW:
               if (tmr_ff <= 8'h01)
               begin
                  link.ctrl_serial_clock <= 1'b1;
                  sh_ff <= {sh_ff[6:0], 1'b0};
                  tmr_ff <= half_sel;
                  st_ff <= ACSC_H_HIGH;
               end
               else
                  tmr_ff <= tmr_ff - 8'h01;
            ACSC_H_HIGH:
               if (tmr_ff > 8'h01)
                  tmr_ff <= tmr_ff - 8'h01;
               else if (cnt_ff == BIT_CNT_LAST)
               begin
                  tmr_ff <= PHASE_GAP_CYC;
                  st_ff <= ACSC_H_GAP;
               end
               else
               begin
                  cnt_ff <= cnt_ff + 4'h1;
                  link.ctrl_serial_clock <= 1'b0;
                  link.ctrl_serial_data <= sh_ff[7];
                  tmr_ff <= half_sel;
                  st_ff <= ACSC_H_LOW;
               end
            ACSC_H_GAP:
               if (tmr_ff <= 8'h01)
               begin
                  if (addr_ph_ff)
                     link.ctrl_phase_line <= 1'b1;
                  st_ff <= ACSC_H_IDLE;
               end
               else
                  tmr_ff <= tmr_ff - 8'h01;
         endcase
      end
   end
endmodule

// File: acsc_chk.sv
// checker: timing and framing of the three-wire control link
`timescale 1ns/1ps
module acsc_chk
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ctrl_phase_line,
   input wire logic ctrl_serial_clock,
   input wire logic ctrl_serial_data
);
   logic sclk_ff;
   logic [3:0] addr_rise_ff;
   logic [2:0] rise_mod_ff;
   logic rise;
   assign rise = ctrl_serial_clock && !sclk_ff;
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         sclk_ff <= 1'b1;
         addr_rise_ff <= 4'h0;
         rise_mod_ff <= 3'h0;
      end
      else
      begin
         sclk_ff <= ctrl_serial_clock;
         if (rise)
            rise_mod_ff <= rise_mod_ff + 3'h1;
         if (ctrl_phase_line)
            addr_rise_ff <= 4'h0;
         else if (rise)
            addr_rise_ff <= addr_rise_ff + 4'h1;
      end
   end
   a_addr_eight_pulses: assert property ($rose(ctrl_phase_line) |-> addr_rise_ff == 4'h8)
      else $error("address byte without eight clock pulses");
   a_addr_bounded: assert property ($fell(ctrl_phase_line) |-> ##[1:400] $rose(ctrl_phase_line))
      else $error("address phase never ended");
   a_whole_bytes: assert property ($changed(ctrl_phase_line) |-> rise_mod_ff == 3'h0)
      else $error("phase change inside a byte");
   a_phase_clk_high: assert property ($changed(ctrl_phase_line) |-> ctrl_serial_clock && $past(ctrl_serial_clock))
      else $error("phase line moved while clock low");
   a_addr_setup_gap: assert property ($fell(ctrl_phase_line) |-> ctrl_serial_clock [*4])
      else $error("clock fell too soon after phase fall");
   a_clk_low_width: assert property ($fell(ctrl_serial_clock) |-> !ctrl_serial_clock [*4])
      else $error("serial clock low phase too short");
   a_clk_high_width: assert property ($rose(ctrl_serial_clock) |-> ctrl_serial_clock [*4])
      else $error("serial clock high phase too short");
   a_data_held_rise: assert property ($rose(ctrl_serial_clock) |-> $stable(ctrl_serial_data))
      else $error("data moved at clock rise");
   c_addr_byte: cover property ($rose(ctrl_phase_line));
   c_data_bit: cover property (ctrl_phase_line && $rose(ctrl_serial_clock));
   c_addr_then_data: cover property ($rose(ctrl_phase_line) ##[1:200] $rose(ctrl_serial_clock));
endmodule

// File: acsc_tb_top.sv
// testbench: controller and codec ends joined over the link, driven over apb
`timescale 1ns/1ps
module acsc_tb_top;
   import acsc_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata, rd;
   logic pready, pslverr, err, mute, ratio_valid, format_valid, dc_filter_en, selected, byte_stored;
   logic [5:0] volume;
   logic [3:0] bass_boost;
   logic [1:0] treble, deemphasis, filter_mode, power_ctrl, clk_ratio;
   logic [9:0] fs_multiple;
   logic [2:0] input_format;
   logic sclk_ff = 1'b1;
   logic [7:0] wire_sr = 8'h00;
   int fail_count = 0;
   int total_checks = 0;
   int stored_n = 0;
   int rise_n = 0;
   acsc_if link ();
   acsc_ctrl i_acsc_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link.ctrl));
   acsc_dev i_acsc_dev (.pclk(pclk), .presetn(presetn), .link(link.dev), .volume(volume), .bass_boost(bass_boost),
      .treble(treble), .deemphasis(deemphasis), .mute(mute), .filter_mode(filter_mode), .power_ctrl(power_ctrl),
      .clk_ratio(clk_ratio), .fs_multiple(fs_multiple), .ratio_valid(ratio_valid), .input_format(input_format),
      .format_valid(format_valid), .dc_filter_en(dc_filter_en), .selected(selected), .byte_stored(byte_stored));
   acsc_chk i_acsc_chk (.pclk(pclk), .presetn(presetn), .ctrl_phase_line(link.ctrl_phase_line),
      .ctrl_serial_clock(link.ctrl_serial_clock), .ctrl_serial_data(link.ctrl_serial_data));
   always #25 pclk = ~pclk;
   // wire monitor: bits taken at each serial clock rise
   always @(posedge pclk)
   begin
      sclk_ff <= link.ctrl_serial_clock;
      if (link.ctrl_serial_clock === 1'b1 && sclk_ff === 1'b0)
      begin
         wire_sr <= {wire_sr[6:0], link.ctrl_serial_data};
         rise_n <= rise_n + 1;
      end
      if (byte_stored === 1'b1)
         stored_n <= stored_n + 1;
   end
   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= addr;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wait_done(input logic [7:0] b, input int r0);
      do
         apb(1'b0, OFF_STAT, 32'h0);
      while (rd[0] !== 1'b0);
      repeat (8) @(posedge pclk);
      chk("wire_byte", {24'h0, wire_sr}, {24'h0, b});
      chk("rise_count", 32'(rise_n - r0), 32'd8);
   endtask
   task automatic send(input logic adr, input logic [7:0] b);
      int r0;
      r0 = rise_n;
      apb(1'b1, OFF_CMD, {23'h0, adr, b});
      chk("cmd_err", {31'h0, err}, 32'h0);
      wait_done(b, r0);
   endtask
   task automatic t_reset();
      chk("fs_rst", 32'(fs_multiple), 32'(FS_MULT_512));
      chk("sel_rst", 32'(selected), 32'h0);
      chk("vol_rst", 32'(volume), 32'(VOLUME_RST));
      apb(1'b0, OFF_DIV, 32'h0);
      chk("div_rst", rd, DIV_RST);
      apb(1'b0, 12'h00c, 32'h0);
      chk("unmapped_err", {31'h0, err}, 32'h1);
   endtask
   task automatic t_general();
      int s0;
      s0 = stored_n;
      send(1'b1, {OWN_ADDR_DEFAULT, TYPE_GENERAL});
      chk("selected", 32'(selected), 32'h1);
      send(1'b0, 8'h2b);
      send(1'b0, 8'h6e);
      send(1'b0, 8'had);
      send(1'b0, 8'hc2);
      chk("volume", 32'(volume), 32'h2b);
      chk("bass", 32'(bass_boost), 32'hb);
      chk("treble", 32'(treble), 32'h2);
      chk("deemph", 32'(deemphasis), 32'h1);
      chk("mute", 32'(mute), 32'h1);
      chk("filt", 32'(filter_mode), 32'h1);
      chk("power", 32'(power_ctrl), 32'h2);
      chk("stored", 32'(stored_n - s0), 32'h4);
   endtask
   task automatic t_desel();
      int s0;
      s0 = stored_n;
      send(1'b1, {OWN_ADDR_DEFAULT ^ 6'h01, TYPE_GENERAL});
      chk("desel", 32'(selected), 32'h0);
      send(1'b0, 8'h15);
      chk("vol_kept", 32'(volume), 32'h2b);
      send(1'b1, {OWN_ADDR_DEFAULT, 2'h1});
      send(1'b0, 8'h15);
      chk("vol_unused", 32'(volume), 32'h2b);
      send(1'b1, {OWN_ADDR_DEFAULT, 2'h3});
      send(1'b0, 8'h15);
      chk("vol_unused3", 32'(volume), 32'h2b);
      chk("no_store", 32'(stored_n - s0), 32'h0);
      send(1'b1, {OWN_ADDR_DEFAULT, TYPE_GENERAL});
      send(1'b0, 8'h15);
      chk("vol_again", 32'(volume), 32'h15);
   endtask
   task automatic t_status();
      logic [9:0] fs;
      int s0;
      send(1'b1, {OWN_ADDR_DEFAULT, TYPE_STATUS});
      for (int i = 0; i < 8; i++)
      begin
         send(1'b0, {2'b00, i[1:0], i[2:0], i[0]});
         fs = (i[1:0] == 2'h1) ? FS_MULT_384 : (i[1:0] == 2'h2) ? FS_MULT_256 : FS_MULT_512;
         chk("ratio", 32'(clk_ratio), 32'(i[1:0]));
         chk("fs_mult", 32'(fs_multiple), 32'(fs));
         chk("ratio_ok", 32'(ratio_valid), 32'(i[1:0] != 2'h3));
         chk("format", 32'(input_format), 32'(i[2:0]));
         chk("format_ok", 32'(format_valid), 32'(i < 5));
         chk("dc_filt", 32'(dc_filter_en), 32'(i[0]));
      end
      s0 = stored_n;
      send(1'b0, 8'h80);
      chk("ign_ratio", 32'(clk_ratio), 32'h3);
      chk("ign_dc", 32'(dc_filter_en), 32'h1);
      chk("ign_store", 32'(stored_n - s0), 32'h0);
   endtask
   task automatic t_apb();
      int r0;
      apb(1'b1, OFF_DIV, 32'h0000_0005);
      apb(1'b0, OFF_DIV, 32'h0);
      chk("div_wr", rd, 32'h0000_0005);
      send(1'b1, {OWN_ADDR_DEFAULT, TYPE_GENERAL});
      r0 = rise_n;
      apb(1'b1, OFF_CMD, 32'h0000_0003);
      apb(1'b1, OFF_CMD, 32'h0000_0004);
      chk("busy_err", {31'h0, err}, 32'h1);
      wait_done(8'h03, r0);
      chk("vol_slow", 32'(volume), 32'h03);
      apb(1'b1, OFF_DIV, DIV_RST);
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial
   begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_general();
      t_desel();
      t_status();
      t_apb();
      wrap_up();
   end
   initial
   begin
      #1_000_000;
      fail_count++;
      wrap_up();
   end
endmodule
